// ==== hbs_pkg.sv ====
package hbs_pkg;

   // time unit constants
   localparam int unsigned CLK_PERIOD_PS  = 50000;   // 20 MHz system clock
   localparam int unsigned DEAD_TIME_NS   = 1000;    // least gap between switch states
   localparam int unsigned DEAD_TIME_CYC  =
      (DEAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned GAP_CNT_W      = 8;

   // controller command lines, sampled as one group
   typedef struct packed {
      logic dir_a;
      logic dir_b;
      logic pwm;
   } hbs_cmd_t;

   // four bridge gate drives
   typedef struct packed {
      logic upper_switch_one;
      logic upper_switch_two;
      logic lower_switch_one;
      logic lower_switch_two;
   } hbs_gate_t;

   localparam hbs_gate_t GATES_OFF = 4'h0;

   // what the bridge is being asked to do
   typedef enum logic [1:0] {
      HBS_STANDBY = 2'b00,
      HBS_FWD     = 2'b01,
      HBS_REV     = 2'b10,
      HBS_ILLEGAL = 2'b11
   } hbs_mode_t;

endpackage

// ==== hbs_bridge_seq.sv ====
`timescale 1ns/1ps

module hbs_bridge_seq #(
   parameter int unsigned DEAD_CYC = hbs_pkg::DEAD_TIME_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire hbs_pkg::hbs_cmd_t cmd,
   output hbs_pkg::hbs_gate_t     gate_r,
   output hbs_pkg::hbs_mode_t     mode_r,
   output logic                   illegal_r
);
   import hbs_pkg::*;

   localparam int unsigned CW = $clog2(DEAD_CYC + 1);

   initial begin
      if (DEAD_CYC < DEAD_TIME_CYC) $error("dead time below one microsecond");
   end

   // decode the requested bridge state from the raw lines
   hbs_mode_t mode_req;
   hbs_gate_t want;
   assign mode_req = hbs_mode_t'({cmd.dir_b, cmd.dir_a});

   // illegal both-high opens every switch with pwm ignored, a safe fallback
   function automatic hbs_gate_t gate_for(input hbs_mode_t m, input logic p);
      hbs_gate_t g;
      g = GATES_OFF;
      case (m)
         HBS_STANDBY: begin
            g.lower_switch_one = 1'b1;
            g.lower_switch_two = 1'b1;
         end
         HBS_FWD: begin
            g.upper_switch_one = p;
            g.lower_switch_two = 1'b1;
         end
         HBS_REV: begin
            g.upper_switch_two = p;
            g.lower_switch_one = 1'b1;
         end
         default: g = GATES_OFF;
      endcase
      return g;
   endfunction

   assign want = gate_for(mode_req, cmd.pwm);

   // per-leg view of wanted and present drives; index 0 is leg one
   wire [1:0] up_want = {want.upper_switch_two, want.upper_switch_one};
   wire [1:0] lo_want = {want.lower_switch_two, want.lower_switch_one};
   wire [1:0] up_on   = {gate_r.upper_switch_two, gate_r.upper_switch_one};
   wire [1:0] lo_on   = {gate_r.lower_switch_two, gate_r.lower_switch_one};
   wire [1:0] hi_clear;   // upper of the leg open for the whole dead time
   wire [1:0] lo_clear;   // lower of the leg open for the whole dead time
   wire [1:0] up_nxt;
   wire [1:0] lo_nxt;

   // one dead-time step: reload while the switch conducts, then count to zero
   function automatic logic [CW-1:0] gap_step(input logic busy, input logic [CW-1:0] cnt);
      logic [CW-1:0] n;
      n = cnt;
      if (busy) begin
         n = CW'(DEAD_CYC);
      end else if (cnt != '0) begin
         n = cnt - 1'b1;
      end
      return n;
   endfunction

   // the timers are per leg: only a switch's own leg partner can short it,
   // so the lower switch of the driven leg stays closed while the far upper
   // chops; a shared timer would hold the upper off for as long as any
   // lower conducts, which is the whole time the motor is driven
   for (genvar leg = 0; leg < 2; leg++) begin : g_leg
      logic [CW-1:0] hi_gap_r;   // high_side_gap: dead-time cycles left since the upper opened
      logic [CW-1:0] lo_gap_r;   // low_side_gap: dead-time cycles left since the lower opened
      wire  [CW-1:0] hi_gap_nxt = gap_step(up_on[leg], hi_gap_r);
      wire  [CW-1:0] lo_gap_nxt = gap_step(lo_on[leg], lo_gap_r);

      assign hi_clear[leg] = !up_on[leg] && (hi_gap_r == '0);
      assign lo_clear[leg] = !lo_on[leg] && (lo_gap_r == '0);

      // opening is immediate; closing waits on the partner, so either
      // release order is safe and a chopping upper needs no fresh dead time
      assign up_nxt[leg] = up_want[leg] && !lo_want[leg]
                           && (up_on[leg] || lo_clear[leg]);
      assign lo_nxt[leg] = lo_want[leg] && !up_want[leg]
                           && (lo_on[leg] || hi_clear[leg]);

      // timers start at zero so the standby short closes right after reset
      always_ff @(posedge clk_sys or negedge arst_n) begin
         if (!arst_n) begin
            hi_gap_r <= '0;
            lo_gap_r <= '0;
         end else begin
            hi_gap_r <= hi_gap_nxt;
            lo_gap_r <= lo_gap_nxt;
         end
      end
   end

   // regroup the leg results into the gate word, upper pair first
   hbs_gate_t gate_nxt;
   assign gate_nxt = {up_nxt[0], up_nxt[1], lo_nxt[0], lo_nxt[1]};

   // output registers; reset leaves every switch open
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         gate_r    <= GATES_OFF;
         mode_r    <= HBS_STANDBY;
         illegal_r <= 1'b0;
      end else begin
         gate_r    <= gate_nxt;
         mode_r    <= mode_req;
         illegal_r <= (mode_req == HBS_ILLEGAL);
      end
   end

   // helper for the checks below: cycles that the decoded mode has held,
   // saturating once every dead timer must have run out
   localparam int unsigned STEADY_MIN = DEAD_CYC + 1;
   localparam int unsigned SW         = $clog2(STEADY_MIN + 1);
   logic [SW-1:0] steady_r;
   wire  [SW-1:0] steady_nxt = (mode_req != mode_r) ? '0
                             : (steady_r == SW'(STEADY_MIN)) ? steady_r
                             : steady_r + 1'b1;
   wire           settled    = (steady_r == SW'(STEADY_MIN)) && (mode_req == mode_r);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         steady_r <= '0;
      end else begin
         steady_r <= steady_nxt;
      end
   end

   // upper and lower of one leg are never on together
   a_leg_no_short: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !(gate_r.upper_switch_one & gate_r.lower_switch_one) &&
      !(gate_r.upper_switch_two & gate_r.lower_switch_two))
      else $error("shoot-through on a bridge leg");

   // an upper switch closes only once its leg's lower was open the dead time
   a_upper_dead_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(gate_r.upper_switch_one) |-> $past(g_leg[0].lo_gap_r) == '0
      && !$past(gate_r.lower_switch_one))
      else $error("upper switch one on inside dead time");

   a_upper_two_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(gate_r.upper_switch_two) |-> $past(g_leg[1].lo_gap_r) == '0
      && !$past(gate_r.lower_switch_two))
      else $error("upper switch two on inside dead time");

   // a lower switch closes only once its leg's upper was open the dead time
   a_lower_one_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(gate_r.lower_switch_one) |-> $past(g_leg[0].hi_gap_r) == '0
      && !$past(gate_r.upper_switch_one))
      else $error("lower switch one on inside dead time");

   a_lower_two_gap: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(gate_r.lower_switch_two) |-> $past(g_leg[1].hi_gap_r) == '0
      && !$past(gate_r.upper_switch_two))
      else $error("lower switch two on inside dead time");

   // the dead timers never hold more than the dead time
   a_gap_in_range: assert property (@(posedge clk_sys) disable iff (!arst_n)
      g_leg[0].hi_gap_r <= DEAD_CYC && g_leg[0].lo_gap_r <= DEAD_CYC
      && g_leg[1].hi_gap_r <= DEAD_CYC && g_leg[1].lo_gap_r <= DEAD_CYC)
      else $error("dead timer out of range");

   // pwm low drops upper switches on the next edge
   a_pwm_low_upper: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !cmd.pwm |=> !gate_r.upper_switch_one && !gate_r.upper_switch_two)
      else $error("upper switch on with pwm low");

   // settled standby shorts the motor through both lower switches
   a_standby_short: assert property (@(posedge clk_sys) disable iff (!arst_n)
      settled && mode_req == HBS_STANDBY |-> gate_r.lower_switch_one
      && gate_r.lower_switch_two)
      else $error("standby brake not applied");

   // settled forward with pwm high conducts the forward loop
   a_forward_loop: assert property (@(posedge clk_sys) disable iff (!arst_n)
      settled && mode_req == HBS_FWD && cmd.pwm |=> gate_r.upper_switch_one
      && gate_r.lower_switch_two && !gate_r.upper_switch_two)
      else $error("forward loop not closed");

   // settled reverse with pwm high conducts the reverse loop
   a_reverse_loop: assert property (@(posedge clk_sys) disable iff (!arst_n)
      settled && mode_req == HBS_REV && cmd.pwm |=> gate_r.upper_switch_two
      && gate_r.lower_switch_one && !gate_r.upper_switch_one)
      else $error("reverse loop not closed");

   // the mode output follows the direction lines one cycle later
   a_mode_follows: assert property (@(posedge clk_sys) disable iff (!arst_n)
      mode_r == $past(mode_req))
      else $error("mode output lags wrongly");

   // illegal input opens every switch
   a_illegal_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (mode_req == HBS_ILLEGAL) |=> gate_r == GATES_OFF && illegal_r)
      else $error("illegal input not parked");

endmodule

// ==== hbs_ctrl_model.sv ====
`timescale 1ns/1ps
// controller stand-in: registered lines, standby in reset, pwm-first braking
module hbs_ctrl_model (
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   input  wire hbs_pkg::hbs_cmd_t want,
   input  wire logic [7:0]        gap_cyc,
   input  wire logic              bad,
   output hbs_pkg::hbs_cmd_t      cmd
);
   import hbs_pkg::*;
   logic [7:0] gap_r;
   logic [1:0] cur_dir;
   logic [1:0] req_dir;
   logic       to_brake;
   // a both-high request folds to standby unless a scenario sets bad
   assign cur_dir  = {cmd.dir_a, cmd.dir_b};
   assign req_dir  = (want.dir_a & want.dir_b) ? 2'h0 : {want.dir_a, want.dir_b};
   assign to_brake = (cur_dir != 2'h0) && (req_dir != cur_dir);
   // the gap trades stopping speed for lower-leg current
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cmd   <= '0;
         gap_r <= 8'h00;
      end else if (bad) begin
         cmd <= want;
      end else if (to_brake && cmd.pwm) begin
         cmd.pwm <= 1'b0;
         gap_r   <= gap_cyc;
      end else if (to_brake && gap_r != 8'h00) begin
         gap_r <= gap_r - 8'h01;
      end else if (to_brake) begin
         {cmd.dir_a, cmd.dir_b} <= 2'h0;
      end else begin
         cmd <= {req_dir, want.pwm};
      end
   end
endmodule

// ==== hbridge_brake_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module hbridge_brake_sequencer_tb_top;
   import hbs_pkg::*;
   logic      clk_sys = 1'b0;
   logic      arst_n = 1'b0;
   logic      bad = 1'b0;
   logic[7:0] gap_cyc = 8'h1e;
   hbs_cmd_t  want = '0;
   hbs_cmd_t  cmd;
   hbs_gate_t gate_r;
   hbs_mode_t mode_r;
   logic      illegal_r;
   int        mismatches = 0;
   int        comparisons = 0;
   hbs_ctrl_model u_hbs_ctrl_model (.clk_sys(clk_sys), .arst_n(arst_n), .want(want),
      .gap_cyc(gap_cyc), .bad(bad), .cmd(cmd));
   hbs_bridge_seq #(.DEAD_CYC(20)) u_hbs_bridge_seq (.clk_sys(clk_sys), .arst_n(arst_n),
      .cmd(cmd), .gate_r(gate_r), .mode_r(mode_r), .illegal_r(illegal_r));
   // 50 ns period
   initial forever #25 clk_sys = ~clk_sys;
   task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic go(input hbs_cmd_t w, input int n);
      @(posedge clk_sys);
      want <= w;
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // bounded wait for a gate pattern, then judge it
   task automatic wait_gate(input hbs_gate_t exp, input int lim);
      for (int n = 0; n < lim && gate_r !== exp; n++) @(posedge clk_sys);
      #1;
      cmp(gate_r, exp);
   endtask
   task automatic s_reset;
      repeat (8) @(posedge clk_sys);
      cmp(gate_r, 4'h0);
      arst_n <= 1'b1;
      wait_gate(4'h3, 40);
      cmp(mode_r, HBS_STANDBY);
   endtask
   task automatic s_drive;
      go(3'b101, 10);
      cmp(gate_r, 4'h1);
      wait_gate(4'h9, 40);
      cmp(mode_r, HBS_FWD);
      go(3'b100, 1);
      wait_gate(4'h1, 4);
      go(3'b101, 1);
      wait_gate(4'h9, 4);
   endtask
   task automatic s_brake;
      go(3'b000, 3);
      cmp(gate_r, 4'h1);
      go(3'b000, 12);
      cmp(gate_r, 4'h1);
      wait_gate(4'h3, 60);
   endtask
   task automatic s_reverse;
      go(3'b011, 10);
      cmp(gate_r, 4'h2);
      wait_gate(4'h6, 40);
      cmp(mode_r, HBS_REV);
      gap_cyc <= 8'h00;
      go(3'b101, 1);
      wait_gate(4'h9, 120);
   endtask
   task automatic s_release;
      s_brake();
      go(3'b001, 5);
      cmp(gate_r, 4'h3);
      go(3'b101, 1);
      wait_gate(4'h9, 40);
      s_brake();
      go(3'b100, 1);
      wait_gate(4'h1, 40);
      go(3'b101, 1);
      wait_gate(4'h9, 40);
   endtask
   task automatic s_illegal;
      bad <= 1'b1;
      go(3'b110, 1);
      wait_gate(4'h0, 4);
      cmp(illegal_r, 1'b1);
      cmp(mode_r, HBS_ILLEGAL);
      bad <= 1'b0;
      go(3'b000, 1);
      wait_gate(4'h3, 60);
      cmp(illegal_r, 1'b0);
   endtask
   // a leg's upper and lower switch must never conduct together
   always @(negedge clk_sys) begin
      if (arst_n) begin
         cmp(gate_r.upper_switch_one & gate_r.lower_switch_one, 1'b0);
         cmp(gate_r.upper_switch_two & gate_r.lower_switch_two, 1'b0);
      end
   end
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      s_reset();
      s_drive();
      s_brake();
      s_reverse();
      s_release();
      s_illegal();
      give_verdict();
   end
   // whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      mismatches++;
      give_verdict();
   end
endmodule
